// file: rtl/hidp_pkg.sv
// Shared constants, state type and helpers of the host memory port.
package hidp_pkg;
    localparam int          ADDR_W          = 14;
    localparam int          DATA_W          = 16;
    localparam int          PM_W            = 24;
    localparam int          OVL_W           = 8;
    localparam int          FIFO_DEPTH      = 32;
    localparam int          ENTRY_W         = 1 + ADDR_W + PM_W;
    localparam logic [13:0] CTRL_REG_ADDR   = 14'h3fe0;
    localparam logic [13:0] SYSCFG_REG_ADDR = 14'h3fe7;
    localparam logic [13:0] CTRL_SPACE_BASE = 14'h3fe0;
    localparam logic [13:0] PM_BOOT_ADDR    = 14'h0000;
    localparam logic [13:0] ADDR_RST        = 14'h0000;
    localparam logic [7:0]  OVL_RST         = 8'h00;
    localparam logic [2:0]  BOOT_MODE       = 3'h5;
    localparam int          CW_OVL_BIT      = 15;
    localparam int          CW_PM_BIT       = 14;
    localparam int          SYSCFG_SHORT_BIT = 14;
    localparam int          STB_AL          = 3;
    localparam int          STB_SEL         = 2;
    localparam int          STB_RD          = 1;
    localparam int          STB_WR          = 0;
    localparam logic [3:0]  STB_IDLE        = 4'h4;

    typedef enum logic [1:0] {
        HIDP_IDLE = 2'h0,
        HIDP_MEM  = 2'h1,
        HIDP_HOLD = 2'h3
    } hidp_state_t;

    function automatic logic hidp_cw_is_ovl(input logic [15:0] w);
        return w[CW_OVL_BIT];
    endfunction : hidp_cw_is_ovl

    function automatic logic hidp_is_ctrl(input logic pm,
                                          input logic [13:0] a);
        return !pm && (a >= CTRL_SPACE_BASE);
    endfunction : hidp_is_ctrl
endpackage : hidp_pkg

// file: rtl/hidp_stream_if.sv
// Valid/ready word stream between the port and its write buffer.
interface hidp_stream_if #(
    parameter int W = 39
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : hidp_stream_if

// file: rtl/hidp_strobe_edge.sv
// Input register for host strobes with edge pulses.
module hidp_strobe_edge #(
    parameter int           W        = 4,
    parameter logic [W-1:0] IDLE_VAL = '0
) (
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] raw,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rose,
    output logic      [W-1:0] fell
);
    logic [W-1:0] lvl_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_q  <= IDLE_VAL;
            prev_q <= IDLE_VAL;
        end else begin
            lvl_q  <= raw;
            prev_q <= lvl_q;
        end
    end

    assign lvl  = lvl_q;
    assign rose = lvl_q & ~prev_q;
    assign fell = ~lvl_q & prev_q;
endmodule : hidp_strobe_edge

// file: rtl/hidp_fifo.sv
// Flip-flop FIFO holding host writes until the core grants a cycle.
module hidp_fifo #(
    parameter int W     = 39,
    parameter int DEPTH = 32
) (
    input  wire logic   core_clk,
    input  wire logic   rst_b,
    hidp_stream_if.snk  in_s,
    hidp_stream_if.src  out_s
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [PW:0]   cnt_q, cnt_d;
    logic          push, pop;

    always_comb begin
        in_s.ready  = (cnt_q != (PW+1)'(DEPTH));
        out_s.valid = (cnt_q != '0);
        out_s.data  = mem_q[rp_q];
        push = in_s.valid && in_s.ready;
        pop  = out_s.valid && out_s.ready;
        wp_d = push ? PW'((wp_q + 1'b1) % DEPTH) : wp_q;
        rp_d = pop ? PW'((rp_q + 1'b1) % DEPTH) : rp_q;
        cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wp_q] <= in_s.data;
        end
    end
endmodule : hidp_fifo

// file: rtl/hidp_port.sv
// Host memory port: control word latch, access sequencer, memory side.
// Notes on behaviour
// (RULE_01) Each word except a dropped control area write costs exactly one granted memory cycle of the core.
// (RULE_02) Host writes into the control register area are dropped.
// (RULE_03) Control word bit 15 set loads overlay from bits 7:0.
// (RULE_04) Bit 15 clear loads start address 13:0 and space bit 14.
// (RULE_05) Host drives address and space only while acknowledge is low.
// (RULE_06) Host waits for acknowledge before starting the next transfer.
// (RULE_07) One 16-bit muxed bus; program words go as two halves.
// (RULE_08) Strobes come in any time; the core never stops for them.
// (RULE_09) Address advances after every completed word.
// (RULE_10) Latch on falling latch strobe or select release during latch.
// (RULE_11) One cycle to synchronise, then one memory cycle.
// (RULE_12) The start address can never be read back over the bus.
// (RULE_13) Core writes at data address 3fe0 load the same control word; one that meets a host latch in the same cycle is dropped.
// (RULE_14) Short read variant input chooses immediate or delayed ack.
// (RULE_15) Reserved control bits must be written as zero.
// (RULE_16) Mode pins C,B,A = 1,0,1 select boot through this port.
// (RULE_17) Boot holds the core until program address 0 is written.
// (RULE_18) Acknowledge goes high at a strobe, low when access is done.
module hidp_port #(
    parameter int FIFO_DEPTH = hidp_pkg::FIFO_DEPTH
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        host_address_latch_strobe,
    input  wire logic        host_port_select_n,
    input  wire logic        host_read_strobe_n,
    input  wire logic        host_write_strobe_n,
    output logic             host_acknowledge_n,
    input  wire logic [15:0] host_muxed_addr_data_bus_in,
    output logic      [15:0] host_muxed_addr_data_bus_out,
    output logic             host_muxed_addr_data_bus_oe_n,
    input  wire logic        mode_a,
    input  wire logic        mode_b,
    input  wire logic        mode_c,
    input  wire logic        short_read_variant,
    input  wire logic        core_ctrl_wr,
    input  wire logic [13:0] core_ctrl_addr,
    input  wire logic [15:0] core_ctrl_wdata,
    output logic             mem_req,
    output logic             mem_we,
    output logic             program_memory_space,
    output logic      [13:0] mem_addr,
    output logic      [23:0] mem_wdata,
    input  wire logic        mem_gnt,
    input  wire logic [23:0] mem_rdata,
    output logic      [7:0]  memory_overlay_select,
    output logic             core_hold
);
    localparam int EW = hidp_pkg::ENTRY_W;
    localparam int AL = hidp_pkg::STB_AL;
    localparam int SL = hidp_pkg::STB_SEL;
    localparam int RD = hidp_pkg::STB_RD;
    localparam int WR = hidp_pkg::STB_WR;

    hidp_pkg::hidp_state_t st_q, st_d;
    logic [3:0]  strb_raw;
    logic [3:0]  strb_lvl;
    logic [3:0]  strb_rose;
    logic [3:0]  strb_fell;
    logic [15:0] bus_q;
    logic [13:0] addr_q, addr_d, addr_inc;
    logic        pm_q, pm_d;
    logic [7:0]  ovl_q, ovl_d;
    logic        half_q, half_d;
    logic [15:0] hi_q, hi_d;
    logic [7:0]  rlo_q, rlo_d;
    logic [15:0] data_q, data_d;
    logic [15:0] out_q, out_d;
    logic        op_wr_q, op_wr_d;
    logic        lag_q, lag_d;
    logic        boot_hold_q, boot_hold_d;
    logic        strap_q, strap_d;
    logic        latch_fire;
    logic        host_latch;
    logic [15:0] cw;
    logic        mem_rd;
    logic        boot_fire;
    logic        raw_busy;
    logic [23:0] wdata24;

    hidp_stream_if #(.W(EW)) push_if ();
    hidp_stream_if #(.W(EW)) pop_if ();

    // The input register is the single synchronising cycle.
    assign strb_raw[AL] = host_address_latch_strobe;
    assign strb_raw[SL] = host_port_select_n;
    assign strb_raw[RD] = !host_port_select_n && !host_read_strobe_n;
    assign strb_raw[WR] = !host_port_select_n && !host_write_strobe_n;

    hidp_strobe_edge #(
        .W        (4),
        .IDLE_VAL (hidp_pkg::STB_IDLE)
    ) u_edge (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .raw      (strb_raw),
        .lvl      (strb_lvl),
        .rose     (strb_rose),
        .fell     (strb_fell)
    );

    // Writes queue here so a busy core stalls the host, not the reverse.
    hidp_fifo #(
        .W     (EW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .in_s     (push_if.snk),
        .out_s    (pop_if.src)
    );

    assign addr_inc = addr_q + 14'h0001;
    assign wdata24  = pm_q ? {hi_q, data_q[7:0]} : {8'h00, data_q};
    assign boot_fire = pop_if.valid && mem_gnt && pop_if.data[EW-1]
        && (pop_if.data[EW-2 -: 14] == hidp_pkg::PM_BOOT_ADDR);

    always_comb begin
        st_d        = st_q;
        addr_d      = addr_q;
        pm_d        = pm_q;
        ovl_d       = ovl_q;
        half_d      = half_q;
        hi_d        = hi_q;
        rlo_d       = rlo_q;
        data_d      = data_q;
        out_d       = out_q;
        op_wr_d     = op_wr_q;
        lag_d       = 1'b0;
        strap_d     = 1'b1;
        boot_hold_d = boot_hold_q;
        mem_rd      = 1'b0;
        push_if.valid = 1'b0;
        push_if.data  = {pm_q, addr_q, wdata24};
        host_latch = strb_fell[AL]
                     || (strb_rose[SL] && strb_lvl[AL]); // see RULE_10
        latch_fire = 1'b0;
        cw         = bus_q;
        if (host_latch) begin
            latch_fire = 1'b1;
        end else if (core_ctrl_wr
                     && core_ctrl_addr == hidp_pkg::CTRL_REG_ADDR) begin
            latch_fire = 1'b1; // see RULE_13
            cw         = core_ctrl_wdata;
        end
        if (latch_fire) begin
            if (hidp_pkg::hidp_cw_is_ovl(cw)) begin
                ovl_d = cw[7:0]; // see RULE_03
            end else begin
                addr_d = cw[13:0]; // see RULE_04
                pm_d   = cw[hidp_pkg::CW_PM_BIT];
                half_d = 1'b0;
            end
        end
        case (st_q)
            hidp_pkg::HIDP_IDLE: begin
                if (strb_rose[RD] || strb_rose[WR]) begin
                    op_wr_d = strb_rose[WR]; // see RULE_11
                    data_d  = bus_q;
                    st_d    = hidp_pkg::HIDP_MEM;
                end
            end
            hidp_pkg::HIDP_MEM: begin
                if (op_wr_q) begin
                    if (pm_q && !half_q) begin
                        hi_d   = data_q; // see RULE_07
                        half_d = 1'b1;
                        st_d   = hidp_pkg::HIDP_HOLD;
                    end else if (hidp_pkg::hidp_is_ctrl(pm_q, addr_q)) begin
                        addr_d = addr_inc; // see RULE_02
                        half_d = 1'b0;
                        st_d   = hidp_pkg::HIDP_HOLD;
                    end else begin
                        push_if.valid = 1'b1; // see RULE_08
                        if (push_if.ready) begin
                            addr_d = addr_inc; // see RULE_09
                            half_d = 1'b0;
                            st_d   = hidp_pkg::HIDP_HOLD;
                        end
                    end
                end else if (pm_q && half_q) begin
                    out_d  = {8'h00, rlo_q}; // see RULE_07
                    addr_d = addr_inc;
                    half_d = 1'b0;
                    lag_d  = !short_read_variant;
                    st_d   = hidp_pkg::HIDP_HOLD;
                end else if (!pop_if.valid) begin
                    // Reads wait for queued writes so they see fresh data.
                    mem_rd = 1'b1;
                    if (mem_gnt) begin
                        lag_d = !short_read_variant; // see RULE_14
                        st_d  = hidp_pkg::HIDP_HOLD;
                        if (pm_q) begin
                            out_d  = mem_rdata[23:8];
                            rlo_d  = mem_rdata[7:0];
                            half_d = 1'b1;
                        end else begin
                            out_d  = mem_rdata[15:0];
                            addr_d = addr_inc; // see RULE_09
                        end
                    end
                end
            end
            hidp_pkg::HIDP_HOLD: begin
                if (!strb_lvl[RD] && !strb_lvl[WR]) begin
                    st_d = hidp_pkg::HIDP_IDLE;
                end
            end
            default: begin
                st_d = hidp_pkg::HIDP_IDLE;
            end
        endcase
        if (!strap_q) begin
            boot_hold_d = ({mode_c, mode_b, mode_a}
                           == hidp_pkg::BOOT_MODE); // see RULE_16
        end else if (boot_hold_q && boot_fire) begin
            boot_hold_d = 1'b0; // see RULE_17
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q        <= hidp_pkg::HIDP_IDLE;
            bus_q       <= 16'h0000;
            addr_q      <= hidp_pkg::ADDR_RST;
            pm_q        <= 1'b0;
            ovl_q       <= hidp_pkg::OVL_RST;
            half_q      <= 1'b0;
            hi_q        <= 16'h0000;
            rlo_q       <= 8'h00;
            data_q      <= 16'h0000;
            out_q       <= 16'h0000;
            op_wr_q     <= 1'b0;
            lag_q       <= 1'b0;
            strap_q     <= 1'b0;
            boot_hold_q <= 1'b1;
        end else begin
            st_q        <= st_d;
            bus_q       <= host_muxed_addr_data_bus_in;
            addr_q      <= addr_d;
            pm_q        <= pm_d;
            ovl_q       <= ovl_d;
            half_q      <= half_d;
            hi_q        <= hi_d;
            rlo_q       <= rlo_d;
            data_q      <= data_d;
            out_q       <= out_d;
            op_wr_q     <= op_wr_d;
            lag_q       <= lag_d;
            strap_q     <= strap_d;
            boot_hold_q <= boot_hold_d;
        end
    end

    // Busy shows at the pins at once, before the input register sees it.
    assign raw_busy = host_address_latch_strobe || strb_raw[RD]
                      || strb_raw[WR];
    assign host_acknowledge_n =
        !((st_q == hidp_pkg::HIDP_IDLE && !raw_busy)
          || (st_q == hidp_pkg::HIDP_HOLD && !lag_q)); // see RULE_18

    // Only memory data ever reaches the bus, never the address.
    assign host_muxed_addr_data_bus_out  = out_q; // see RULE_12
    assign host_muxed_addr_data_bus_oe_n =
        !(st_q == hidp_pkg::HIDP_HOLD && !op_wr_q && strb_lvl[RD]);

    // One request per word; the queue owns the port whenever it has data.
    assign pop_if.ready         = mem_gnt;
    assign mem_req              = pop_if.valid || mem_rd; // see RULE_01
    assign mem_we               = pop_if.valid;
    assign program_memory_space = pop_if.valid ? pop_if.data[EW-1] : pm_q;
    assign mem_addr  = pop_if.valid ? pop_if.data[EW-2 -: 14] : addr_q;
    assign mem_wdata = pop_if.data[23:0];
    assign memory_overlay_select = ovl_q;
    assign core_hold = boot_hold_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_access_seen;
        st_q == hidp_pkg::HIDP_IDLE && (strb_rose[RD] || strb_rose[WR]);
    endsequence
    sequence s_strap_boot;
        !strap_q && {mode_c, mode_b, mode_a} == hidp_pkg::BOOT_MODE;
    endsequence

    property p_sync_mem;
        s_access_seen |=> st_q == hidp_pkg::HIDP_MEM;
    endproperty
    a_sync_mem: assert property (p_sync_mem) // see RULE_11
        else $error("access did not enter memory cycle");
    property p_ack_busy;
        st_q == hidp_pkg::HIDP_MEM |-> host_acknowledge_n;
    endproperty
    a_ack_busy: assert property (p_ack_busy) // see RULE_18
        else $error("acknowledge low during memory cycle");
    property p_ovl_latch;
        latch_fire && cw[15] |=> memory_overlay_select == $past(cw[7:0]);
    endproperty
    a_ovl_latch: assert property (p_ovl_latch) // see RULE_03
        else $error("overlay not loaded");
    property p_addr_latch;
        latch_fire && !cw[15] |=> addr_q == $past(cw[13:0])
            && pm_q == $past(cw[14]);
    endproperty
    a_addr_latch: assert property (p_addr_latch) // see RULE_04
        else $error("start address not loaded");
    property p_al_edge;
        strb_fell[AL] && !bus_q[15] |=> addr_q == $past(bus_q[13:0]);
    endproperty
    a_al_edge: assert property (p_al_edge) // see RULE_10
        else $error("latch edge missed");
    property p_core_map;
        core_ctrl_wr && core_ctrl_addr == hidp_pkg::CTRL_REG_ADDR
            && !host_latch && !core_ctrl_wdata[15]
            |=> addr_q == $past(core_ctrl_wdata[13:0]);
    endproperty
    a_core_map: assert property (p_core_map) // see RULE_13
        else $error("core control write ignored");
    property p_ctrl_guard;
        push_if.valid |-> !hidp_pkg::hidp_is_ctrl(pm_q, addr_q);
    endproperty
    a_ctrl_guard: assert property (p_ctrl_guard) // see RULE_02
        else $error("write to control area queued");
    property p_incr;
        push_if.valid && push_if.ready
            |=> addr_q == 14'($past(addr_q) + 14'h0001);
    endproperty
    a_incr: assert property (p_incr) // see RULE_09
        else $error("address not advanced");
    property p_one_steal;
        mem_rd && mem_gnt |=> st_q == hidp_pkg::HIDP_HOLD && !mem_rd;
    endproperty
    a_one_steal: assert property (p_one_steal) // see RULE_01
        else $error("read took more than one cycle");
    property p_readback;
        !host_muxed_addr_data_bus_oe_n |-> !op_wr_q
            && st_q == hidp_pkg::HIDP_HOLD;
    endproperty
    a_readback: assert property (p_readback) // see RULE_12
        else $error("bus driven outside read data phase");
    property p_variant;
        mem_rd && mem_gnt && !short_read_variant
            |=> host_acknowledge_n;
    endproperty
    a_variant: assert property (p_variant) // see RULE_14
        else $error("delayed variant acknowledged early");
    property p_pm_half;
        st_q == hidp_pkg::HIDP_MEM && op_wr_q && pm_q && !half_q
            |-> !push_if.valid ##1 half_q;
    endproperty
    a_pm_half: assert property (p_pm_half) // see RULE_07
        else $error("program word half mishandled");
    property p_boot_hold;
        s_strap_boot |=> core_hold [*2];
    endproperty
    a_boot_hold: assert property (p_boot_hold) // see RULE_16
        else $error("boot strap did not hold core");
    property p_boot_release;
        strap_q && boot_hold_q && boot_fire |=> !core_hold;
    endproperty
    a_boot_release: assert property (p_boot_release) // see RULE_17
        else $error("core not released by boot word");
endmodule : hidp_port

// file: bench/hidp_mem_model.sv
// Core memory model that grants stolen cycles to the host port.
module hidp_mem_model (
    input  wire logic        core_clk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic        program_memory_space,
    input  wire logic [13:0] mem_addr,
    input  wire logic [23:0] mem_wdata,
    input  wire logic [1:0]  pace,
    output logic             mem_gnt,
    output logic      [23:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] mem_q [0:32767];
    logic [1:0]  tick_q;
    initial begin
        tick_q = 2'h0;
        for (int i = 0; i < 32768; i++) mem_q[i] = 24'h000000;
    end
    // Pace 0 grants at once, 1 one cycle in four, 2 never (a busy core).
    assign mem_gnt = mem_req && (pace == 2'h0 ||
                     (pace == 2'h1 && tick_q == 2'h0));
    // Outside a grant the data lines show a changing pattern, not old data.
    assign mem_rdata = mem_gnt ? mem_q[{program_memory_space, mem_addr}]
                               : {tick_q, 22'h2aaaaa};
    always @(posedge core_clk) begin
        tick_q <= tick_q + 2'h1;
        if (mem_gnt && mem_we) begin
            mem_q[{program_memory_space, mem_addr}] <= mem_wdata;
        end
    end
endmodule : hidp_mem_model

// file: bench/test_hidp_port.sv
// Self-checking bench of the host memory port.
module test_hidp_port;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk;
    logic        rst_b = 1'b0, al = 1'b0, cwr = 1'b0, srv = 1'b1;
    logic        sel_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
    logic        m_a = 1'b0, m_b = 1'b0, m_c = 1'b0;
    logic        ack_n, oe_n, req, we, pms, gnt, hold;
    logic [15:0] bus_in, bus_out, got, cdat = 16'h0000;
    logic [15:0] host_d = 16'h0000;
    logic [15:0] ex [0:5];
    logic [13:0] caddr = 14'h0000, maddr, addr;
    logic [23:0] wdat, wdmem, rdmem;
    logic [7:0]  ovl;
    logic [1:0]  pace = 2'h0;
    int          seed = 90, miscompares = 0, check_count = 0, n;
    int          lat [0:1];
    // The host lets go of the bus while the port drives it.
    assign bus_in = oe_n ? host_d : bus_out;
    hidp_port #(.FIFO_DEPTH(4)) hidp_port_inst (
        .core_clk(core_clk), .rst_b(rst_b),
        .host_address_latch_strobe(al), .host_port_select_n(sel_n),
        .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
        .host_acknowledge_n(ack_n), .host_muxed_addr_data_bus_in(bus_in),
        .host_muxed_addr_data_bus_out(bus_out),
        .host_muxed_addr_data_bus_oe_n(oe_n),
        .mode_a(m_a), .mode_b(m_b), .mode_c(m_c), .short_read_variant(srv),
        .core_ctrl_wr(cwr), .core_ctrl_addr(caddr), .core_ctrl_wdata(cdat),
        .mem_req(req), .mem_we(we), .program_memory_space(pms),
        .mem_addr(addr), .mem_wdata(wdmem), .mem_gnt(gnt),
        .mem_rdata(rdmem), .memory_overlay_select(ovl), .core_hold(hold));
    hidp_mem_model hidp_mem_model_inst (
        .core_clk(core_clk), .mem_req(req), .mem_we(we),
        .program_memory_space(pms), .mem_addr(addr), .mem_wdata(wdmem),
        .pace(pace), .mem_gnt(gnt), .mem_rdata(rdmem));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task automatic wait_ack(input int lim);
        n = 0;
        while (ack_n !== 1'b0) begin
            @(negedge core_clk);
            n++;
            if (n > lim) begin
                chk("ack wait", 24'h0, 24'h1);
                final_report();
            end
        end
    endtask : wait_ack
    task automatic latch(input logic [15:0] w);
        wait_ack(50);
        @(negedge core_clk);
        al = 1'b1;
        host_d = w;
        @(negedge core_clk);
        al = 1'b0;
        repeat (3) @(negedge core_clk);
        chk("latch drive", 24'h1, {23'h0, oe_n});
    endtask : latch
    // Strobe held until the acknowledge is seen; n is cycles from strobe.
    task automatic xfer(input logic w, input logic [15:0] d);
        wait_ack(50);
        @(negedge core_clk);
        sel_n = 1'b0;
        if (w) wr_n = 1'b0;
        else rd_n = 1'b0;
        host_d = w ? d : ~host_d;
        @(negedge core_clk);
        chk("ack busy", 24'h1, {23'h0, ack_n});
        wait_ack(200);
        n = n + 1;
        got = bus_out;
        if (!w) chk("bus drive", 24'h0, {23'h0, oe_n});
        sel_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(negedge core_clk);
    endtask : xfer
    initial begin
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("no boot", 24'h0, {23'h0, hold});
        for (int k = 0; k < 2; k++) begin
            pace = 2'(k);
            maddr = 14'($random(seed)) & 14'h1fff;
            latch({2'b00, maddr});
            for (int i = 0; i < 6; i++) begin
                ex[i] = 16'($random(seed));
                xfer(1'b1, ex[i]);
                chk("write time", 24'h1, {23'h0, n >= 2});
            end
            latch({2'b00, maddr});
            for (int i = 0; i < 6; i++) begin
                xfer(1'b0, 16'h0000);
                chk("dm read", {8'h00, ex[i]}, {8'h00, got});
            end
            chk("dm mem", {8'h00, ex[5]},
                hidp_mem_model_inst.mem_q[{1'b0, maddr + 14'h5}]);
        end
        @(negedge core_clk);
        cwr = 1'b1;
        caddr = 14'h3fe0;
        cdat = {2'b00, maddr + 14'h2};
        @(negedge core_clk);
        cwr = 1'b0;
        xfer(1'b0, 16'h0000);
        chk("core latch", {8'h00, ex[2]}, {8'h00, got});
        // Select rising with the latch strobe high takes the word; the
        // later latch fall carries an overlay word so the address stays.
        wait_ack(50);
        @(negedge core_clk);
        al = 1'b1;
        sel_n = 1'b0;
        host_d = {2'b00, maddr + 14'h4};
        @(negedge core_clk);
        sel_n = 1'b1;
        @(negedge core_clk);
        al = 1'b0;
        host_d = 16'h8000;
        repeat (3) @(negedge core_clk);
        xfer(1'b0, 16'h0000);
        chk("select latch", {8'h00, ex[4]}, {8'h00, got});
        pace = 2'h0;
        for (int j = 0; j < 2; j++) begin
            srv = j[0];
            wdat = 24'($random(seed));
            latch({2'b01, maddr});
            xfer(1'b1, wdat[23:8]);
            xfer(1'b1, {8'h00, wdat[7:0]});
            latch({2'b01, maddr});
            xfer(1'b0, 16'h0000);
            lat[j] = n;
            chk("pm high", {8'h00, wdat[23:8]}, {8'h00, got});
            xfer(1'b0, 16'h0000);
            chk("pm low", 24'(wdat[7:0]), 24'(got[7:0]));
            chk("pm mem", wdat,
                hidp_mem_model_inst.mem_q[{1'b1, maddr}]);
        end
        chk("short read", 24'h1, 24'(lat[0] == lat[1] + 1));
        latch(16'h3fe5);
        xfer(1'b1, 16'h5a5a);
        repeat (4) @(negedge core_clk);
        chk("ctrl guard", 24'h0,
            hidp_mem_model_inst.mem_q[15'h3fe5]);
        latch({8'h80, 8'($random(seed))});
        chk("overlay", 24'(host_d[7:0]), 24'(ovl));
        // A stalled core lets the buffer fill until the port holds off.
        pace = 2'h2;
        latch({2'b00, maddr});
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, 16'(i));
            chk("buffer room", 24'h1, {23'h0, n < 10});
        end
        fork
            begin
                repeat (40) @(negedge core_clk);
                pace = 2'h1;
            end
        join_none
        xfer(1'b1, 16'h0004);
        chk("buffer full", 24'h1, {23'h0, n > 30});
        repeat (30) @(negedge core_clk);
        chk("buffer drain", 24'h000004,
            hidp_mem_model_inst.mem_q[{1'b0, maddr + 14'h4}]);
        rst_b = 1'b0;
        m_c = 1'b1;
        m_a = 1'b1;
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge core_clk);
        chk("boot hold", 24'h1, {23'h0, hold});
        pace = 2'h0;
        latch(16'h0000);
        xfer(1'b1, 16'h1234);
        latch(16'h4000);
        xfer(1'b1, 16'h5678);
        repeat (4) @(negedge core_clk);
        chk("boot half", 24'h1, {23'h0, hold});
        xfer(1'b1, 16'h009a);
        repeat (4) @(negedge core_clk);
        chk("boot run", 24'h0, {23'h0, hold});
        final_report();
    end
endmodule : test_hidp_port
